// >>> inc/fieldbus_node_pkg.sv
// fieldbus_node_pkg: shared constants and types of the node status block.
// assumes a 100 MHz system clock and a 32-bit APB register bus.
package fieldbus_node_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          TICK_NS       = 1000000;
    localparam int          TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
    localparam int          MS_W          = 12;
    localparam logic [11:0] CAN_HOLD_MS   = 12'h7D0;
    localparam logic [11:0] COPEN_ON_MS   = 12'h1F4;
    localparam logic [11:0] COPEN_OFF_MS  = 12'h1F4;
    localparam logic [11:0] DN_SHORT_MS   = 12'h0C8;
    localparam logic [11:0] DN_LONG_MS    = 12'h320;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_ADDR     = 8'h04;
    localparam logic [7:0] OFS_BAUD     = 8'h08;
    localparam logic [7:0] OFS_PROF     = 8'h0C;
    localparam logic [7:0] OFS_STATUS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    localparam int ADDR_W = 7;
    localparam int BAUD_W = 4;
    localparam int PROF_W = 2;
    localparam int IRQ_W  = 4;

    localparam int STAT_BAUD_POS = 8;
    localparam int STAT_PROF_POS = 16;
    localparam int STAT_LAMP_POS = 24;
    localparam int STAT_CONN_POS = 25;
    localparam int STAT_DN_POS   = 26;

    localparam int IRQ_RX_POS   = 0;
    localparam int IRQ_LOST_POS = 1;
    localparam int IRQ_DN_POS   = 2;
    localparam int IRQ_DUP_POS  = 3;

    localparam logic              RST_PIN_SRC = 1'b0;
    localparam logic [ADDR_W-1:0] RST_ADDR    = 7'h01;
    localparam logic [BAUD_W-1:0] RST_BAUD    = 4'h0;
    localparam logic [IRQ_W-1:0]  RST_MASK    = 4'h0;

    // ----------------------------------------------------------------
    // profiles, node states, lamp modes
    // ----------------------------------------------------------------
    localparam logic [PROF_W-1:0] PROF_CAN   = 2'h0;
    localparam logic [PROF_W-1:0] PROF_COPEN = 2'h1;
    localparam logic [PROF_W-1:0] PROF_DNET  = 2'h2;
    localparam logic [PROF_W-1:0] RST_PROF   = 2'h0;

    typedef enum logic [1:0] {
        DN_OFFLINE, DN_DUPCHECK, DN_LINK_OK, DN_FAILURE
    } dnState_t;

    typedef enum logic [2:0] {
        LAMP_OFF, LAMP_ON, LAMP_HOLD, LAMP_EQ5,
        LAMP_SHORT, LAMP_LONG, LAMP_EQ2
    } lampMode_t;

endpackage

// >>> core/lamp_timer.sv
// lamp_timer: millisecond prescaler and phase counter for the lamp.
// assumes restart is a same-clock level; period zero saturates the count.
`timescale 1ns/1ps
`default_nettype none
module lamp_timer #(
    parameter int TICK_CYCLES = fieldbus_node_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    // control
    input  wire logic                               restart,
    input  wire logic [fieldbus_node_pkg::MS_W-1:0] periodMs,
    // count
    output logic      [fieldbus_node_pkg::MS_W-1:0] msCount
);
    import fieldbus_node_pkg::*;

    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [MS_W-1:0]  cnt;
    } timerState_t;

    timerState_t st_q;
    timerState_t st_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (restart) begin
            st_d.pre = '0; // RL13
            st_d.cnt = '0; // RL13
        end else if (st_q.pre == PRE_LAST) begin
            st_d.pre = '0;
            if (periodMs != '0 && st_q.cnt == periodMs - 12'h001) begin
                st_d.cnt = '0;
            end else if (st_q.cnt != '1) begin
                st_d.cnt = st_q.cnt + 12'h001;
            end
        end else begin
            st_d.pre = st_q.pre + PRE_W'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign msCount = st_q.cnt;

endmodule
`default_nettype wire

// >>> core/fieldbus_node_status_config.sv
// fieldbus_node_status_config: status lamp and configuration source logic.
// assumes the protocol engine runs on clk_sys; strap pins are asynchronous.
// Notes on behaviour
// (RL1) node is slave, reports status only
// (RL2) node address settable, unique on network
// (RL3) plain CAN: lamp two seconds per reception
// (RL4) CANopen: lamp steady while connected
// (RL5) CANopen lost: blink 0.5 on/0.5 off
// (RL6) DeviceNet link established: lamp steady on
// (RL7) DeviceNet offline: 0.2 on, 0.8 off
// (RL8) DeviceNet duplicate check: 0.8 on, 0.2 off
// (RL9) DeviceNet timeout/failure: 0.2 on/0.2 off
// (RL10) address from stored value or pins
// (RL11) bit rate from stored value or pins
// (RL12) profile from stored value or pins
// (RL13) one ms counter, restarts on display change
// (RL14) source select chooses stored or pin values
`timescale 1ns/1ps
`default_nettype none
module fieldbus_node_status_config #(
    parameter int TICK_CYCLES = fieldbus_node_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    // apb slave
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [7:0]                           paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    // strap pins
    input  wire logic [fieldbus_node_pkg::ADDR_W-1:0] addrPins,
    input  wire logic [fieldbus_node_pkg::BAUD_W-1:0] baudPins,
    input  wire logic [fieldbus_node_pkg::PROF_W-1:0] profPins,
    // protocol engine
    input  wire logic                                 rxOk,
    input  wire logic                                 connUp,
    input  wire fieldbus_node_pkg::dnState_t          dnState,
    input  wire logic                                 dupAddr,
    output logic      [fieldbus_node_pkg::ADDR_W-1:0] nodeAddr,
    output logic      [fieldbus_node_pkg::BAUD_W-1:0] bitRate,
    output logic      [fieldbus_node_pkg::PROF_W-1:0] busProfile,
    // indicators
    output logic                                      statusLamp,
    output logic                                      irq
);
    import fieldbus_node_pkg::*;

    localparam int PIN_W = ADDR_W + BAUD_W + PROF_W;

    typedef struct packed {
        logic [PIN_W-1:0]  pinMeta;
        logic [PIN_W-1:0]  pinSync;
        logic              pinSrc;
        logic [ADDR_W-1:0] storedAddr;
        logic [BAUD_W-1:0] storedBaud;
        logic [PROF_W-1:0] storedProf;
        logic [ADDR_W-1:0] effAddr;
        logic [BAUD_W-1:0] effBaud;
        logic [PROF_W-1:0] effProf;
        lampMode_t         mode;
        logic              rxSeen;
        logic              connPrev;
        dnState_t          dnPrev;
        logic [IRQ_W-1:0]  irqStat;
        logic [IRQ_W-1:0]  irqMask;
        logic              irq;
        logic              lamp;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } nodeState_t;

    nodeState_t st_q;
    nodeState_t st_d;

    logic [MS_W-1:0] msCount;
    logic [MS_W-1:0] periodMs;
    logic            restart;
    logic            canRx;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [MS_W-1:0] lampOnMs(input lampMode_t m);
        unique case (m)
            LAMP_OFF:   lampOnMs = '0;
            LAMP_ON:    lampOnMs = '1;
            LAMP_HOLD:  lampOnMs = CAN_HOLD_MS;
            LAMP_EQ5:   lampOnMs = COPEN_ON_MS;
            LAMP_SHORT: lampOnMs = DN_SHORT_MS;
            LAMP_LONG:  lampOnMs = DN_LONG_MS;
            LAMP_EQ2:   lampOnMs = DN_SHORT_MS;
        endcase
    endfunction

    function automatic logic [MS_W-1:0] lampPeriodMs(input lampMode_t m);
        unique case (m)
            LAMP_OFF, LAMP_ON, LAMP_HOLD: lampPeriodMs = '0;
            LAMP_EQ5:   lampPeriodMs = COPEN_ON_MS + COPEN_OFF_MS;
            LAMP_SHORT, LAMP_LONG: lampPeriodMs = DN_SHORT_MS + DN_LONG_MS;
            LAMP_EQ2:   lampPeriodMs = DN_SHORT_MS + DN_SHORT_MS;
        endcase
    endfunction

    function automatic logic known(input logic [7:0] a);
        known = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_BAUD)
             || (a == OFS_PROF) || (a == OFS_STATUS)
             || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic             wrAcc;
    logic             rdLaunch;
    logic [IRQ_W-1:0] irqEvents;
    logic [IRQ_W-1:0] irqClear;
    logic [31:0]      rdWord;

    always_comb begin
        st_d      = st_q;
        irqEvents = '0;
        irqClear  = '0;
        rdWord    = '0;
        canRx     = rxOk && (st_q.effProf == PROF_CAN);

        // pin synchroniser, first stage read only by the second
        st_d.pinMeta = {addrPins, baudPins, profPins};
        st_d.pinSync = st_q.pinMeta;

        // source select between stored values and pins
        if (st_q.pinSrc) begin // RL14
            st_d.effAddr = st_q.pinSync[PIN_W-1 -: ADDR_W]; // RL10
            st_d.effBaud = st_q.pinSync[PROF_W +: BAUD_W]; // RL11
            st_d.effProf = st_q.pinSync[PROF_W-1:0]; // RL12
        end else begin
            st_d.effAddr = st_q.storedAddr; // RL10
            st_d.effBaud = st_q.storedBaud; // RL11
            st_d.effProf = st_q.storedProf; // RL12
        end

        // reception hold in plain CAN, retriggered by every reception
        if (canRx) begin
            st_d.rxSeen = 1'b1; // RL3
        end else if (st_q.effProf != PROF_CAN
                     || (st_q.mode == LAMP_HOLD
                         && msCount >= CAN_HOLD_MS)) begin
            st_d.rxSeen = 1'b0; // RL3
        end

        // displayed state from profile and node state
        if (st_q.effProf == PROF_CAN) begin
            st_d.mode = st_d.rxSeen ? LAMP_HOLD : LAMP_OFF; // RL3
        end else if (st_q.effProf == PROF_COPEN) begin
            st_d.mode = connUp ? LAMP_ON : LAMP_EQ5; // RL4 RL5
        end else if (st_q.effProf == PROF_DNET) begin
            unique case (dnState)
                DN_OFFLINE:  st_d.mode = LAMP_SHORT; // RL7
                DN_DUPCHECK: st_d.mode = LAMP_LONG; // RL8
                DN_LINK_OK:  st_d.mode = LAMP_ON; // RL6
                DN_FAILURE:  st_d.mode = LAMP_EQ2; // RL9
            endcase
        end else begin
            // reserved profile code: lamp stays dark
            st_d.mode = LAMP_OFF;
        end

        // lamp from current mode and phase count
        st_d.lamp = (st_q.mode == LAMP_ON)
                 || (msCount < lampOnMs(st_q.mode));

        // interrupt events, set wins over a clear in the same cycle
        st_d.connPrev = connUp;
        st_d.dnPrev   = dnState;
        irqEvents[IRQ_RX_POS]   = rxOk;
        irqEvents[IRQ_LOST_POS] = st_q.connPrev && !connUp;
        irqEvents[IRQ_DN_POS]   = st_q.effProf == PROF_DNET
                               && st_q.dnPrev != dnState;
        irqEvents[IRQ_DUP_POS]  = dupAddr; // RL2

        // apb: ready one cycle into access, effect at the sampled edge
        wrAcc    = psel && penable && st_q.pready && pwrite;
        rdLaunch = psel && penable && !st_q.pready;
        st_d.pready = rdLaunch;
        if (rdLaunch) begin
            st_d.pslverr = !known(paddr);
            unique case (paddr)
                OFS_CTRL:     rdWord[0] = st_q.pinSrc;
                OFS_ADDR:     rdWord[ADDR_W-1:0] = st_q.storedAddr;
                OFS_BAUD:     rdWord[BAUD_W-1:0] = st_q.storedBaud;
                OFS_PROF:     rdWord[PROF_W-1:0] = st_q.storedProf;
                OFS_STATUS: begin
                    // node status as reported back, never initiated
                    rdWord[ADDR_W-1:0] = st_q.effAddr; // RL1
                    rdWord[STAT_BAUD_POS +: BAUD_W] = st_q.effBaud;
                    rdWord[STAT_PROF_POS +: PROF_W] = st_q.effProf;
                    rdWord[STAT_LAMP_POS] = st_q.lamp;
                    rdWord[STAT_CONN_POS] = connUp;
                    rdWord[STAT_DN_POS +: 2] = dnState;
                end
                OFS_IRQ_STAT: rdWord[IRQ_W-1:0] = st_q.irqStat;
                OFS_IRQ_MASK: rdWord[IRQ_W-1:0] = st_q.irqMask;
                default:      rdWord = '0;
            endcase
            st_d.prdata = pwrite ? 32'h0000_0000 : rdWord;
        end else if (!st_q.pready) begin
            st_d.prdata  = '0;
            st_d.pslverr = 1'b0;
        end
        if (wrAcc) begin
            unique case (paddr)
                OFS_CTRL:     st_d.pinSrc = pwdata[0]; // RL14
                OFS_ADDR:     st_d.storedAddr = pwdata[ADDR_W-1:0]; // RL2
                OFS_BAUD:     st_d.storedBaud = pwdata[BAUD_W-1:0];
                OFS_PROF:     st_d.storedProf = pwdata[PROF_W-1:0];
                OFS_IRQ_STAT: irqClear = pwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: st_d.irqMask = pwdata[IRQ_W-1:0];
                default:      st_d.pinSrc = st_q.pinSrc;
            endcase
        end
        st_d.irqStat = (st_q.irqStat & ~irqClear) | irqEvents;
        st_d.irq     = |(st_d.irqStat & st_d.irqMask);
    end

    // phase counter restarts on any display change or CAN retrigger
    assign restart  = (st_d.mode != st_q.mode) || canRx; // RL13
    assign periodMs = lampPeriodMs(st_d.mode);

    lamp_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .restart  (restart),
        .periodMs (periodMs),
        .msCount  (msCount)
    );

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q            <= '0;
            st_q.pinSrc     <= RST_PIN_SRC;
            st_q.storedAddr <= RST_ADDR;
            st_q.storedBaud <= RST_BAUD;
            st_q.storedProf <= RST_PROF;
            st_q.effAddr    <= RST_ADDR;
            st_q.effBaud    <= RST_BAUD;
            st_q.effProf    <= RST_PROF;
            st_q.mode       <= LAMP_OFF;
            st_q.dnPrev     <= DN_OFFLINE;
            st_q.irqMask    <= RST_MASK;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata     = st_q.prdata;
    assign pready     = st_q.pready;
    assign pslverr    = st_q.pslverr;
    assign nodeAddr   = st_q.effAddr;
    assign bitRate    = st_q.effBaud;
    assign busProfile = st_q.effProf;
    assign statusLamp = st_q.lamp;
    assign irq        = st_q.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_can_hold_on: assert property ( // RL3
        canRx |-> ##2 statusLamp)
        else $error("lamp not lit after CAN reception");
    a_open_steady: assert property ( // RL4
        (st_q.effProf == PROF_COPEN && connUp)[*2] |=> statusLamp)
        else $error("lamp dark while CANopen connected");
    a_open_blink: assert property ( // RL5
        st_q.mode == LAMP_EQ5 |-> msCount < COPEN_ON_MS + COPEN_OFF_MS)
        else $error("CANopen blink period overrun");
    a_dnet_link_on: assert property ( // RL6
        (st_q.effProf == PROF_DNET && dnState == DN_LINK_OK)[*2]
        |=> statusLamp)
        else $error("lamp dark in link established state");
    a_dnet_offline: assert property ( // RL7
        st_q.mode == LAMP_SHORT && msCount >= DN_SHORT_MS |=> !statusLamp)
        else $error("offline blink on-phase too long");
    a_dnet_dupcheck: assert property ( // RL8
        st_q.mode == LAMP_LONG && msCount < DN_LONG_MS |=> statusLamp)
        else $error("duplicate check on-phase too short");
    a_dnet_failure: assert property ( // RL9
        st_q.mode == LAMP_EQ2 |-> msCount < DN_SHORT_MS + DN_SHORT_MS)
        else $error("failure blink period overrun");
    a_addr_source: assert property ( // RL10
        st_q.pinSrc && $stable(st_q.pinSrc)
        |=> nodeAddr == $past(st_q.pinSync[PIN_W-1 -: ADDR_W]))
        else $error("node address not taken from pins");
    a_baud_source: assert property ( // RL11
        !st_q.pinSrc |=> bitRate == $past(st_q.storedBaud))
        else $error("bit rate not taken from stored value");
    a_prof_source: assert property ( // RL12
        st_q.pinSrc |=> busProfile == $past(st_q.pinSync[PROF_W-1:0]))
        else $error("profile not taken from pins");
    a_mode_restart: assert property ( // RL13
        $changed(st_q.mode) |-> msCount == '0)
        else $error("phase counter not restarted");
    a_apb_ready: assert property ( // RL1
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb ready not one-cycle pulse");

    c_can_rx:    cover property (canRx ##2 statusLamp);
    c_open_lost: cover property (st_q.mode == LAMP_ON ##1
                                 st_q.mode == LAMP_EQ5);
    c_dnet_fail: cover property (st_q.mode == LAMP_EQ2 && statusLamp);
    c_irq:       cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> bench/fieldbus_master_model.sv
// fieldbus_master_model: far-side protocol engine and bus master stand-in.
// assumes bench requests are levels sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // bench requests
    input  wire logic                        sendFrame,
    input  wire logic                        linkReq,
    input  wire fieldbus_node_pkg::dnState_t dnReq,
    input  wire logic                        dupReq,
    // engine side
    output logic                             rxOk,
    output logic                             connUp,
    output fieldbus_node_pkg::dnState_t      dnState,
    output logic                             dupAddr
);
    import fieldbus_node_pkg::*;
    // ------------------------------------------------------------
    // one edge of delay, like a real engine output stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxOk    <= 1'b0;
            connUp  <= 1'b0;
            dnState <= DN_OFFLINE;
            dupAddr <= 1'b0;
        end else begin
            rxOk    <= sendFrame;
            connUp  <= linkReq;
            dnState <= dnReq;
            dupAddr <= dupReq;
        end
    end
endmodule
`default_nettype wire

// >>> bench/test_fieldbus_node_status_config.sv
// test_fieldbus_node_status_config: APB driven self-checking bench.
// assumes a 4-cycle ms tick, so lamp phases are ms times four cycles.
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_node_status_config;
    import fieldbus_node_pkg::*;
    localparam int T   = 4;
    localparam int TOL = 12;
    logic clk_sys = 1'b0, rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rxOk, connUp, dupAddr, statusLamp, irq, err;
    logic [ADDR_W-1:0] addrPins = 7'h00, nodeAddr;
    logic [BAUD_W-1:0] baudPins = 4'h0, bitRate;
    logic [PROF_W-1:0] profPins = 2'h0, busProfile;
    logic sendFrame = 1'b0, linkReq = 1'b0, dupReq = 1'b0;
    dnState_t dnReq = DN_OFFLINE, dnState;
    int n_fail = 0, checks = 0, n, m;
    int onMs[4] = '{200, 800, 0, 200};
    int offMs[4] = '{800, 200, 0, 200};

    always #5 clk_sys = ~clk_sys;

    fieldbus_node_status_config #(.TICK_CYCLES(T))
        fieldbus_node_status_config_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .addrPins(addrPins),
        .baudPins(baudPins), .profPins(profPins), .rxOk(rxOk),
        .connUp(connUp), .dnState(dnState), .dupAddr(dupAddr),
        .nodeAddr(nodeAddr), .bitRate(bitRate), .busProfile(busProfile),
        .statusLamp(statusLamp), .irq(irq));

    fieldbus_master_model fieldbus_master_model_i (
        .clk_sys(clk_sys), .rst(rst), .sendFrame(sendFrame),
        .linkReq(linkReq), .dnReq(dnReq), .dupReq(dupReq), .rxOk(rxOk),
        .connUp(connUp), .dnState(dnState), .dupAddr(dupAddr));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // apb master: hold request until pready sampled high
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            end_sim;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input logic expErr);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, expErr});
    endtask

    // ------------------------------------------------------------
    // lamp helpers
    // ------------------------------------------------------------
    task automatic run(input logic v, input int lim, output int c);
        c = 0;
        while (statusLamp === v && c < lim) begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= lim) begin
            n_fail++;
            end_sim;
        end
    endtask

    task automatic steady(input logic v, input int cyc);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            if (statusLamp !== v) bad++;
        end
        check(bad, 0);
    endtask

    task automatic blink(input int onC, input int offC);
        run(1'b1, 20000, n);
        run(1'b0, 20000, n);
        run(1'b1, 20000, n);
        run(1'b0, 20000, m);
        check({31'h0, n >= onC - TOL && n <= onC + TOL}, 32'h1);
        check({31'h0, m >= offC - TOL && m <= offC + TOL}, 32'h1);
    endtask

    task automatic frame;
        @(posedge clk_sys);
        sendFrame <= 1'b1;
        @(posedge clk_sys);
        sendFrame <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(OFS_CTRL, 32'h0, 1'b0);
        rdchk(OFS_ADDR, 32'h1, 1'b0);
        rdchk(OFS_BAUD, 32'h0, 1'b0);
        rdchk(OFS_PROF, 32'h0, 1'b0);
        rdchk(OFS_IRQ_MASK, 32'h0, 1'b0);
        rdchk(8'h1C, 32'h0, 1'b1);
        apb(1'b1, OFS_ADDR, 32'h55);
        apb(1'b1, OFS_BAUD, 32'hA);
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        rdchk(OFS_STATUS, 32'h00000A55, 1'b0);
        check({25'h0, nodeAddr}, 32'h55);
        check({28'h0, bitRate}, 32'hA);
        addrPins <= 7'h2A;
        baudPins <= 4'h5;
        profPins <= 2'h2;
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (4) @(posedge clk_sys);
        check({25'h0, nodeAddr}, 32'h2A);
        check({28'h0, bitRate}, 32'h5);
        check({30'h0, busProfile}, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (4) @(posedge clk_sys);
        check({25'h0, nodeAddr}, 32'h55);
        check({30'h0, busProfile}, 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        frame;
        run(1'b0, 20, n);
        check({31'h0, irq}, 32'h1);
        repeat (4000) @(posedge clk_sys);
        frame;
        run(1'b1, 20000, n);
        // hold runs from the retrigger, not from the first frame
        check({31'h0, n >= 2000 * T - TOL
               && n <= 2000 * T + TOL}, 32'h1);
        rdchk(OFS_IRQ_STAT, 32'h1, 1'b0);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_PROF, 32'h3);
        frame;
        steady(1'b0, 100);
        apb(1'b1, OFS_PROF, 32'h1);
        linkReq <= 1'b1;
        repeat (5) @(posedge clk_sys);
        steady(1'b1, 3000);
        rdchk(OFS_STATUS, 32'h0301_0A55, 1'b0);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        linkReq <= 1'b0;
        blink(500 * T, 500 * T);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'hF);
        rdchk(OFS_IRQ_STAT, 32'h0, 1'b0);
        apb(1'b1, OFS_PROF, 32'h2);
        apb(1'b1, OFS_IRQ_MASK, 32'h4);
        for (int s = 0; s < 4; s++) begin
            dnReq <= dnState_t'(s[1:0]);
            repeat (5) @(posedge clk_sys);
            if (s == 2) begin
                steady(1'b1, 3000);
                rdchk(OFS_STATUS, 32'h0902_0A55, 1'b0);
            end else begin
                blink(onMs[s] * T, offMs[s] * T);
            end
        end
        check({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_MASK, 32'h8);
        apb(1'b1, OFS_IRQ_STAT, 32'hF);
        @(posedge clk_sys);
        dupReq <= 1'b1;
        @(posedge clk_sys);
        dupReq <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        rdchk(OFS_IRQ_STAT, 32'h8, 1'b0);
        end_sim;
    end
endmodule
`default_nettype wire
